// *** hw/sffpo_pkg.sv ***
// Constants, timing counts and opcode framing helpers for the serial flash link.
// Assumes a 10 MHz system clock on the host side and on the device's slow side.
// Function
// [R1] Device starts in clock mode 3 after reset.
// [R2] Data output stays undriven until output needed.
// [R3] Each instruction starts on chip-select falling edge.
// [R4] Select falling edge samples clock idle level: mode.
// [R5] Commands ignored while power-on reset is active.
// [R6] Host waits 50 us before first selection.
// [R7] Host waits 20 ms before program or erase.
// [R8] After power-up device idles in standby.
// [R9] 88h/89h: page address only, no dummy bytes.
// [R10] D2h/E8h: page and byte, four dummy bytes.
// [R11] D4h/D6h buffer address plus one dummy; D1h none.
// [R12] Address: 4 reserved, 11 page, 9 byte bits.
// [R13] 9Fh, B9h, ABh, D7h: opcode byte only.
// [R14] Bits shift in MSB first, opcode then address.
package sffpo_pkg;
    localparam int unsigned SYS_CLK_HZ     = 10_000_000;
    localparam int unsigned SEL_DELAY_US   = 50;
    localparam int unsigned WRITE_DELAY_MS = 20;
    localparam int unsigned SEL_DELAY_CYC  = (SEL_DELAY_US * SYS_CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned WRITE_DELAY_CYC = (WRITE_DELAY_MS * SYS_CLK_HZ + 999) / 1_000;

    localparam int          CNT_W           = 18;
    localparam logic [17:0] SEL_DELAY_CNT   = 18'(SEL_DELAY_CYC);
    localparam logic [17:0] WRITE_DELAY_CNT = 18'(WRITE_DELAY_CYC);
    localparam logic [17:0] POR_CNT_MAX     = 18'h3ffff;
    localparam logic [2:0]  HALF_CYC        = 3'h4;
    localparam logic        MODE_AFTER_RST  = 1'b1;

    localparam int PAGE_BITS = 11;
    localparam int BYTE_BITS = 9;
    localparam int PAGE_LSB  = 9;
    localparam logic [6:0] OPCODE_LAST_BIT = 7'h07;
    localparam logic [6:0] ADDR_FIRST_BIT  = 7'h08;
    localparam logic [6:0] ADDR_END_BIT    = 7'h20;
    localparam logic [6:0] DATA_BITS       = 7'h08;

    localparam logic [7:0] OP_88H = 8'h88;
    localparam logic [7:0] OP_89H = 8'h89;
    localparam logic [7:0] OP_9FH = 8'h9f;
    localparam logic [7:0] OP_B9H = 8'hb9;
    localparam logic [7:0] OP_ABH = 8'hab;
    localparam logic [7:0] OP_D1H = 8'hd1;
    localparam logic [7:0] OP_D2H = 8'hd2;
    localparam logic [7:0] OP_D4H = 8'hd4;
    localparam logic [7:0] OP_D6H = 8'hd6;
    localparam logic [7:0] OP_D7H = 8'hd7;
    localparam logic [7:0] OP_E8H = 8'he8;

    // Bytes that follow the opcode: address bytes plus don't-care bytes.
    function automatic logic [3:0] hdr_bytes(input logic [7:0] op);
        case (op)
            OP_88H, OP_89H, OP_D1H: hdr_bytes = 4'h3; // [R9] [R11]
            OP_D2H, OP_E8H:         hdr_bytes = 4'h7; // [R10]
            OP_D4H, OP_D6H:         hdr_bytes = 4'h4; // [R11]
            OP_9FH, OP_B9H, OP_ABH, OP_D7H: hdr_bytes = 4'h0; // [R13]
            default:                hdr_bytes = 4'h3;
        endcase
    endfunction

    function automatic logic [6:0] hdr_bits(input logic [7:0] op);
        hdr_bits = {hdr_bytes(op), 3'h0} + 7'h08;
    endfunction

    function automatic logic page_used(input logic [7:0] op);
        page_used = (hdr_bytes(op) != 4'h0) && (op != OP_D1H) && (op != OP_D4H)
                    && (op != OP_D6H); // [R11]
    endfunction

    function automatic logic byte_used(input logic [7:0] op);
        byte_used = (hdr_bytes(op) != 4'h0) && (op != OP_88H) && (op != OP_89H); // [R9]
    endfunction

    function automatic logic returns_data(input logic [7:0] op);
        case (op)
            OP_D1H, OP_D2H, OP_D4H, OP_D6H, OP_E8H, OP_9FH, OP_D7H: returns_data = 1'b1;
            default: returns_data = 1'b0;
        endcase
    endfunction

    // Opcode, then reserved nibble, page and byte fields, then four zero dummy bytes.
    function automatic logic [63:0] pack_hdr(input logic [7:0] op, input logic [10:0] page,
                                             input logic [8:0] byte_addr);
        logic [10:0] p;
        logic [8:0]  b;
        p = page_used(op) ? page : 11'h000;
        b = byte_used(op) ? byte_addr : 9'h000;
        pack_hdr = {op, 4'h0, p, b, 32'h0000_0000}; // [R12] [R14]
    endfunction
endpackage

// *** hw/sffpo_link_if.sv ***
// Serial link between the host controller and the flash device.
// The data-out line is resolved here; an undriven line reads high.
`timescale 1ns/10ps
`default_nettype none
interface sffpo_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    assign so_line = so_oe ? so : 1'b1;

    modport host (output sck, output cs_n, output si, input so_line);
    modport device (input sck, input cs_n, input si, output so, output so_oe);
endinterface
`default_nettype wire

// *** hw/sffpo_sync2.sv ***
// Two-flip-flop level synchroniser.
// Assumes the input is a level that stays put for several destination clocks.
`timescale 1ns/10ps
`default_nettype none
module sffpo_sync2 (
    input  wire logic clk_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clk_in) begin
        meta_reg <= d_in;
        sync_reg <= meta_reg;
    end

    assign q_out = sync_reg;
endmodule
`default_nettype wire

// *** hw/sffpo_device.sv ***
// Flash device end: frames opcode, address and dummy bytes on the link clock
// and reports each decoded command header on the 10 MHz system side.
// Assumes rst_in is the internal power-on reset and the host drives the link.
`timescale 1ns/10ps
`default_nettype none
module sffpo_device
    import sffpo_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    sffpo_link_if.device     link,
    input  wire logic [7:0]  reply_data_in,
    output logic             cmd_valid_out,
    output logic [7:0]       cmd_opcode_out,
    output logic [10:0]      cmd_page_out,
    output logic [8:0]       cmd_byte_out,
    output logic             mode3_out,
    output logic             standby_out
);
    // Link clock domain.
    logic        ready_meta_reg;
    logic        ready_lk_reg;
    logic [6:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  opcode_reg;
    logic [23:0] addr_reg;
    logic        hdr_done_reg;
    logic        evt_tgl_reg;
    logic        so_reg;
    logic        so_oe_reg;
    logic [2:0]  out_idx_reg;

    // System clock domain.
    logic        cs_s;
    logic        sck_s;
    logic        tgl_s;
    logic        por_done_reg;
    logic        cs_prev_reg;
    logic        tgl_seen_reg;
    logic        mode_reg;
    logic        valid_reg;
    logic [7:0]  op_out_reg;
    logic [10:0] page_out_reg;
    logic [8:0]  byte_out_reg;
    logic [7:0]  reply_hold_reg;
    logic        standby_reg;

    // Header decoding runs on the link clock. hdr_last marks the rising edge that
    // takes the header's final bit; for a bare opcode that is the eighth edge.
    wire [7:0] shift_next = {shift_reg[6:0], link.si};
    wire       at_op_bit  = (bit_cnt_reg == OPCODE_LAST_BIT);
    wire [7:0] cur_op     = at_op_bit ? shift_next : opcode_reg;
    wire       hdr_last   = !hdr_done_reg && (bit_cnt_reg >= OPCODE_LAST_BIT)
                            && (bit_cnt_reg == hdr_bits(cur_op) - 7'h01);
    wire       in_addr    = (bit_cnt_reg >= ADDR_FIRST_BIT) && (bit_cnt_reg < ADDR_END_BIT);
    wire       drive_now  = hdr_done_reg && ready_lk_reg && returns_data(opcode_reg);

    // The power-on reset clears the link-side ready pair at once, since the link clock
    // may stand still during it; release takes two link edges.
    always_ff @(posedge link.sck or posedge rst_in) begin
        if (rst_in) begin
            ready_meta_reg <= 1'b0;
            ready_lk_reg   <= 1'b0;
        end else begin
            ready_meta_reg <= 1'b1;
            ready_lk_reg   <= ready_meta_reg;
        end
    end

    // A high chip select ends any frame, so every instruction restarts at bit zero.
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_cnt_reg  <= 7'h00; // [R3]
            shift_reg    <= 8'h00;
            hdr_done_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next; // [R14]
            if (!hdr_done_reg) begin
                bit_cnt_reg <= bit_cnt_reg + 7'h01;
            end
            if (hdr_last) begin
                hdr_done_reg <= 1'b1; // [R9] [R10] [R11] [R13]
            end
        end
    end

    // Header words are held past the frame so the system side can read them
    // after the toggle crosses; the next frame needs eight edges to disturb them.
    always_ff @(posedge link.sck) begin
        if (!link.cs_n && at_op_bit) begin
            opcode_reg <= shift_next; // [R14]
        end
        if (!link.cs_n && in_addr && !hdr_done_reg) begin
            addr_reg <= {addr_reg[22:0], link.si}; // [R12]
        end
    end

    // The header event crosses as a toggle, not a pulse, so none is lost whatever
    // the ratio of the two clocks. The reset enters here asynchronously; a frame in
    // flight at its release is ignored only if its header ends within two link edges, while the ready pair is still low.
    always_ff @(posedge link.sck or posedge rst_in) begin
        if (rst_in) begin
            evt_tgl_reg <= 1'b0;
        end else if (!link.cs_n && hdr_last && ready_lk_reg) begin
            evt_tgl_reg <= ~evt_tgl_reg; // [R5]
        end
    end

    // Output changes on the falling edge so the host sees it on the next rise.
    // A deselect clears the enable at once, without waiting for a link edge,
    // so the line is never left driven between frames.
    always_ff @(negedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            so_reg      <= 1'b0; // [R2]
            so_oe_reg   <= 1'b0; // [R2]
            out_idx_reg <= 3'h0;
        end else if (drive_now) begin
            so_oe_reg   <= 1'b1;
            so_reg      <= reply_hold_reg[3'h7 - out_idx_reg];
            out_idx_reg <= out_idx_reg + 3'h1;
        end
    end

    // The line resolves to its pull-up level whenever so_oe is low, so the host
    // reads ones from a released or reset device.
    assign link.so    = so_reg;
    assign link.so_oe = so_oe_reg;

    // Select and clock are pins to this side, so each passes two flip-flops
    // before the mode and standby logic may read it.
    sffpo_sync2 u_cs_sync (
        .clk_in (sys_clk_in),
        .d_in   (link.cs_n),
        .q_out  (cs_s)
    );

    sffpo_sync2 u_sck_sync (
        .clk_in (sys_clk_in),
        .d_in   (link.sck),
        .q_out  (sck_s)
    );

    sffpo_sync2 u_tgl_sync (
        .clk_in (sys_clk_in),
        .d_in   (evt_tgl_reg),
        .q_out  (tgl_s)
    );

    // Select and clock pass equal synchronisers, so a clock level that settles
    // before select falls is what the mode logic sees at the fall. A host that
    // moves both in one cycle would be read at the clock's new level.
    wire cs_fall = cs_prev_reg && !cs_s;
    wire new_cmd = por_done_reg && (tgl_s != tgl_seen_reg);

    // Fields that an opcode leaves unused read as zero, so address bits left
    // over from an earlier frame never reach the outputs.
    wire [10:0] page_sel = page_used(opcode_reg) ? addr_reg[PAGE_LSB +: PAGE_BITS]
                                                 : 11'h000; // [R9] [R11]
    wire [8:0]  byte_sel = byte_used(opcode_reg) ? addr_reg[BYTE_BITS-1:0]
                                                 : 9'h000; // [R9]

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            por_done_reg   <= 1'b0; // [R5]
            cs_prev_reg    <= 1'b1;
            tgl_seen_reg   <= 1'b0;
            mode_reg       <= MODE_AFTER_RST; // [R1]
            valid_reg      <= 1'b0;
            op_out_reg     <= 8'h00;
            page_out_reg   <= 11'h000;
            byte_out_reg   <= 9'h000;
            reply_hold_reg <= 8'h00;
            standby_reg    <= 1'b0;
        end else begin
            por_done_reg <= 1'b1;
            cs_prev_reg  <= cs_s;
            tgl_seen_reg <= tgl_s;
            valid_reg    <= new_cmd;
            standby_reg  <= por_done_reg && cs_s; // [R8]
            // The mode is not taken from the pins in the first cycle after release, so a
            // select that fell during reset leaves the mode at its reset value.
            if (cs_fall && por_done_reg) begin
                mode_reg <= sck_s; // [R4]
            end
            // The reply byte is only taken while deselected, so the link side
            // never sees it change mid-frame.
            if (cs_s) begin
                reply_hold_reg <= reply_data_in;
            end
            if (new_cmd) begin
                op_out_reg   <= opcode_reg;
                page_out_reg <= page_sel; // [R12]
                byte_out_reg <= byte_sel; // [R12]
            end
        end
    end

    // The valid pulse lasts one system cycle; the fields behind it hold until the next.
    assign cmd_valid_out  = valid_reg;
    assign cmd_opcode_out = op_out_reg;
    assign cmd_page_out   = page_out_reg;
    assign cmd_byte_out   = byte_out_reg;
    assign mode3_out      = mode_reg;
    assign standby_out    = standby_reg;
endmodule
`default_nettype wire

// *** hw/sffpo_host.sv ***
// Host controller end: waits out the power-up delays, then frames one
// instruction per accepted request and returns one data byte where due.
// Assumes the device end sits on the same link interface.
`timescale 1ns/10ps
`default_nettype none
module sffpo_host
    import sffpo_pkg::*;
#(
    parameter logic [17:0] WRITE_ALLOWED_CYCLES = WRITE_DELAY_CNT
)
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    sffpo_link_if.host       link,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic        cmd_mode3_in,
    input  wire logic [7:0]  cmd_opcode_in,
    input  wire logic [10:0] cmd_page_in,
    input  wire logic [8:0]  cmd_byte_in,
    output logic             cmd_ready_out,
    output logic             rx_valid_out,
    output logic [7:0]       rx_data_out
);
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_GAP} sffpo_hstate_t;

    sffpo_hstate_t state_reg;
    logic [2:0]    tmr_reg;
    logic [17:0]   por_cnt_reg;
    logic          sck_reg;
    logic          cs_n_reg;
    logic          si_reg;
    logic          mode3_reg;
    logic [63:0]   tx_reg;
    logic [6:0]    bit_cnt_reg;
    logic [6:0]    total_reg;
    logic [6:0]    hdr_reg;
    logic          rd_reg;
    logic [7:0]    rx_sr_reg;
    logic [7:0]    rx_data_reg;
    logic          rx_valid_reg;
    logic          so_s;

    sffpo_sync2 u_so_sync (
        .clk_in (sys_clk_in),
        .d_in   (link.so_line),
        .q_out  (so_s)
    );

    wire        sel_ok   = (por_cnt_reg >= SEL_DELAY_CNT); // [R6]
    wire        wr_ok    = (por_cnt_reg >= WRITE_ALLOWED_CYCLES); // [R7]
    wire        tmr_end  = (tmr_reg == HALF_CYC - 3'h1);
    wire        accept   = cmd_valid_in && cmd_ready_out;
    wire [63:0] hdr_word = pack_hdr(cmd_opcode_in, cmd_page_in, cmd_byte_in);
    wire        last_bit = (bit_cnt_reg == total_reg - 7'h01);

    assign cmd_ready_out = (state_reg == H_IDLE) && sel_ok && (!cmd_write_in || wr_ok); // [R7]

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            por_cnt_reg <= 18'h00000;
        end else if (por_cnt_reg != POR_CNT_MAX) begin
            por_cnt_reg <= por_cnt_reg + 18'h00001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_reg    <= H_IDLE;
            tmr_reg      <= 3'h0;
            sck_reg      <= MODE_AFTER_RST;
            cs_n_reg     <= 1'b1; // [R6]
            si_reg       <= 1'b0;
            mode3_reg    <= MODE_AFTER_RST;
            tx_reg       <= 64'h0;
            bit_cnt_reg  <= 7'h00;
            total_reg    <= 7'h00;
            hdr_reg      <= 7'h00;
            rd_reg       <= 1'b0;
            rx_sr_reg    <= 8'h00;
            rx_data_reg  <= 8'h00;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            tmr_reg      <= tmr_end ? 3'h0 : tmr_reg + 3'h1;
            case (state_reg)
                H_IDLE: begin
                    tmr_reg <= 3'h0;
                    sck_reg <= mode3_reg;
                    // The clock takes its new idle level a cycle before select falls,
                    // so a mode change never reaches the device as a clock edge.
                    if (accept) begin
                        sck_reg     <= cmd_mode3_in; // [R4]
                        mode3_reg   <= cmd_mode3_in;
                        si_reg      <= hdr_word[63]; // [R14]
                        tx_reg      <= {hdr_word[62:0], 1'b0};
                        bit_cnt_reg <= 7'h00;
                        hdr_reg     <= hdr_bits(cmd_opcode_in);
                        rd_reg      <= returns_data(cmd_opcode_in);
                        total_reg   <= hdr_bits(cmd_opcode_in)
                                       + (returns_data(cmd_opcode_in) ? DATA_BITS : 7'h00);
                        state_reg   <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    cs_n_reg <= 1'b0; // [R3]
                    if (tmr_end) begin
                        sck_reg   <= 1'b0;
                        state_reg <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tmr_end) begin
                        sck_reg   <= 1'b1;
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tmr_end) begin
                        if (bit_cnt_reg >= hdr_reg) begin
                            rx_sr_reg <= {rx_sr_reg[6:0], so_s};
                        end
                        bit_cnt_reg <= bit_cnt_reg + 7'h01;
                        if (last_bit) begin
                            cs_n_reg  <= 1'b1;
                            sck_reg   <= mode3_reg;
                            state_reg <= H_GAP;
                        end else begin
                            sck_reg   <= 1'b0;
                            si_reg    <= tx_reg[63]; // [R14]
                            tx_reg    <= {tx_reg[62:0], 1'b0};
                            state_reg <= H_LOW;
                        end
                    end
                end
                H_GAP: begin
                    if (tmr_end) begin
                        state_reg    <= H_IDLE;
                        rx_valid_reg <= rd_reg;
                        if (rd_reg) begin
                            rx_data_reg <= rx_sr_reg;
                        end
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign link.sck      = sck_reg;
    assign link.cs_n     = cs_n_reg;
    assign link.si       = si_reg;
    assign rx_valid_out  = rx_valid_reg;
    assign rx_data_out   = rx_data_reg;
endmodule
`default_nettype wire

// *** test/sffpo_link_checker.sv ***
// Checker for the serial flash link, watching the link wires on the host clock.
// Assumes the host end makes the link clock and is reset by rst_in.
`timescale 1ns/10ps
`default_nettype none
module sffpo_link_checker (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic so_oe
);
    localparam int SEL_CYC = 500;
    logic [9:0] rel_reg;
    logic [6:0] bit_reg;
    logic [7:0] op_reg;
    logic       sck_reg;
    logic       cs_reg;
    // A clock edge in the same cycle as the select fall is a mode change, not a bit.
    wire        rise_w = !cs_n && !cs_reg && sck && !sck_reg;

    function automatic logic [6:0] hdr_len(input logic [7:0] op);
        case (op)
            8'h9f, 8'hb9, 8'hab, 8'hd7: hdr_len = 7'h08;
            8'hd4, 8'hd6: hdr_len = 7'h28;
            8'hd2, 8'he8: hdr_len = 7'h40;
            default: hdr_len = 7'h20;
        endcase
    endfunction

    function automatic logic has_data(input logic [7:0] op);
        has_data = op inside {8'hd1, 8'hd2, 8'hd4, 8'hd6, 8'he8, 8'h9f, 8'hd7};
    endfunction

    always_ff @(posedge sys_clk_in) begin
        sck_reg <= sck;
        cs_reg  <= cs_n;
        rel_reg <= rst_in ? 10'h000 : rel_reg + {9'h000, rel_reg != 10'h3ff};
        bit_reg <= cs_n ? 7'h00 : bit_reg + {6'h00, rise_w};
        if (rise_w && bit_reg < 7'h08) begin
            op_reg <= {op_reg[6:0], si};
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    oe_idle_a: assert property (cs_n && $past(cs_n) |-> !so_oe)
        else $error("data out driven while deselected");
    oe_hold_a: assert property ($fell(so_oe) |-> cs_n)
        else $error("data out released inside a frame");
    oe_start_a: assert property ($rose(so_oe) |-> has_data(op_reg) && bit_reg == hdr_len(op_reg))
        else $error("data out started at the wrong bit");
    frame_len_a: assert property ($rose(cs_n) |->
        bit_reg == hdr_len(op_reg) + (has_data(op_reg) ? 7'h08 : 7'h00))
        else $error("frame length does not fit its opcode");
    sck_idle_a: assert property ($fell(cs_n) |-> $stable(sck))
        else $error("link clock moved as select fell");
    cs_high_a: assert property ($rose(cs_n) |=> cs_n [*3])
        else $error("select high time too short");
    sel_wait_a: assert property ($fell(cs_n) |-> rel_reg >= SEL_CYC)
        else $error("device selected too early after reset");
    si_hold_a: assert property (!cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");

    cover property ($rose(so_oe));
    cover property ($fell(cs_n) && sck);
    cover property ($fell(cs_n) && !sck);
endmodule
`default_nettype wire

// *** test/serial_flash_frame_and_power_on_tb_top.sv ***
// Testbench joining the host and device ends over one serial link.
// Assumes the host makes the link clock; the bench drives both user sides.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_frame_and_power_on_tb_top;
    localparam logic [17:0] WR_CYC = 18'h00258;
    logic        clk, rst_h, rst_d, vld, wr, m3, rdy, rxv, cmdv, m3o, stby;
    logic [7:0]  op, rx, reply, d_op;
    logic [10:0] pg, d_pg;
    logic [8:0]  by, d_by;
    int          err_count, cmp_count, cyc, nv, k;
    logic [7:0]  ops [11] = '{8'h88, 8'h89, 8'h9f, 8'hb9, 8'hab, 8'hd1, 8'hd2, 8'hd4, 8'hd6,
                              8'hd7, 8'he8};

    sffpo_link_if lnk ();
    sffpo_host #(.WRITE_ALLOWED_CYCLES(WR_CYC)) sffpo_host_inst (
        .sys_clk_in(clk), .rst_in(rst_h), .link(lnk.host), .cmd_valid_in(vld),
        .cmd_write_in(wr), .cmd_mode3_in(m3), .cmd_opcode_in(op), .cmd_page_in(pg),
        .cmd_byte_in(by), .cmd_ready_out(rdy), .rx_valid_out(rxv), .rx_data_out(rx));
    sffpo_device sffpo_device_inst (
        .sys_clk_in(clk), .rst_in(rst_d), .link(lnk.device), .reply_data_in(reply),
        .cmd_valid_out(cmdv), .cmd_opcode_out(d_op), .cmd_page_out(d_pg),
        .cmd_byte_out(d_by), .mode3_out(m3o), .standby_out(stby));
    sffpo_link_checker sffpo_link_checker_inst (.sys_clk_in(clk), .rst_in(rst_h),
        .sck(lnk.sck), .cs_n(lnk.cs_n), .si(lnk.si), .so_oe(lnk.so_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= rst_h ? 0 : cyc + 1;
        if (cmdv === 1'b1) begin
            nv <= nv + 1;
        end
    end

    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic lim(input int i, input int n);
        if (i >= n) begin
            err_count++;
            close_out();
        end
    endtask

    // Which fields a header carries: {data byte, page, byte}.
    function automatic logic [2:0] use_of(input logic [7:0] o);
        case (o)
            8'h88, 8'h89: use_of = 3'b010;
            8'hd1, 8'hd4, 8'hd6: use_of = 3'b101;
            8'hd2, 8'he8: use_of = 3'b111;
            8'h9f, 8'hd7: use_of = 3'b100;
            8'hb9, 8'hab: use_of = 3'b000;
            default: use_of = 3'b011;
        endcase
    endfunction

    // One command; ign marks a device held in reset, which must not answer.
    task automatic run(input logic [7:0] o, input logic m, input logic w, input logic ign,
                       input logic [10:0] p, input logic [8:0] b);
        int         i;
        int         t;
        int         n0;
        logic [2:0] u;
        u = use_of(o);
        @(negedge clk);
        n0 = nv;
        op = o;
        m3 = m;
        wr = w;
        pg = p;
        by = b;
        reply = 8'($urandom);
        vld = 1'b1;
        for (i = 0; i < 1000 && rdy !== 1'b1; i++) @(negedge clk);
        lim(i, 1000);
        t = cyc;
        @(negedge clk);
        vld = 1'b0;
        if (w) chk(32'(t < int'(WR_CYC)), 32'h0);
        for (i = 0; i < 20 && lnk.cs_n !== 1'b0; i++) @(negedge clk);
        lim(i, 20);
        for (i = 0; i < 700 && lnk.cs_n !== 1'b1; i++) @(negedge clk);
        lim(i, 700);
        for (i = 0; i < 12 && u[2] && rxv !== 1'b1; i++) @(negedge clk);
        lim(i, 12);
        if (u[2]) chk(rx, ign ? 8'hff : reply);
        repeat (8) @(negedge clk);
        chk(nv - n0, ign ? 0 : 1);
        chk(m3o, ign ? 1'b1 : m);
        chk(stby, !ign);
        if (!ign) begin
            chk(d_op, o);
            chk(d_pg, u[1] ? p : 11'h000);
            chk(d_by, u[0] ? b : 9'h000);
        end
    endtask

    initial begin
        {rst_h, rst_d} = 2'b11;
        {vld, wr, m3} = 3'b000;
        op = 8'h00;
        pg = 11'h000;
        by = 9'h000;
        reply = 8'h00;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(88));
        repeat (20) @(negedge clk);
        chk(stby, 1'b0);
        chk(m3o, 1'b1);
        {rst_h, rst_d} = 2'b00;
        repeat (4) @(negedge clk);
        chk(stby, 1'b1);
        run(8'hd2, 1'b0, 1'b1, 1'b0, 11'h7ff, 9'h1ff);
        for (k = 0; k < 11; k++) begin
            run(ops[k], k[0], 1'b0, 1'b0, 11'($urandom), 9'($urandom));
        end
        for (k = 0; k < 12; k++) begin
            run(8'($urandom), 1'($urandom_range(1)), 1'($urandom_range(1)), 1'b0,
                11'($urandom), 9'($urandom));
        end
        run(8'h88, 1'b1, 1'b0, 1'b0, 11'h000, 9'h1ff);
        rst_d = 1'b1;
        repeat (4) @(negedge clk);
        run(8'h9f, 1'b0, 1'b0, 1'b1, 11'h000, 9'h000);
        rst_d = 1'b0;
        repeat (4) @(negedge clk);
        chk(m3o, 1'b1);
        run(8'hd4, 1'b0, 1'b0, 1'b0, 11'h5a5, 9'h0a5);
        close_out();
    end
endmodule
`default_nettype wire
